// ==== mgxo_pkg.sv ====
// Package with constants, codes and carriers of the magnetometer gain, mode and X result block.
package mgxo_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 25;
    // One delay step of the conversion start delay, in milliseconds.
    localparam real         DELAY_STEP_MS  = 0.333;
    localparam int unsigned DELAY_STEP_CYC =
        int'($floor(DELAY_STEP_MS * 1.0e6 / real'(CLK_PERIOD_NS)));
    // Nominal output rate used as the default output period.
    localparam real         OUT_RATE_HZ    = 10.0;
    localparam int unsigned OUT_PERIOD_CYC =
        int'($floor(1.0e9 / (OUT_RATE_HZ * real'(CLK_PERIOD_NS))));
    localparam int unsigned TMR_W          = 32;

    // ------------------------------------------------------------------
    // Register addresses and pointer limits
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_PTR_ZERO = 8'h00;
    localparam logic [7:0] REG_CFG_B    = 8'h01;
    localparam logic [7:0] REG_MODE     = 8'h02;
    localparam logic [7:0] REG_X_UPPER  = 8'h03;
    localparam logic [7:0] REG_X_LOWER  = 8'h04;
    localparam logic [7:0] REG_OUT_LAST = 8'h08;
    localparam logic [7:0] REG_PTR_TOP  = 8'h0C;
    localparam int unsigned OUT_REGS    = 6;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned GAIN_MSB  = 7;
    localparam int unsigned GAIN_LSB  = 5;
    localparam int unsigned DELAY_MSB = 3;
    localparam int unsigned DELAY_LSB = 0;
    localparam int unsigned MODE_MSB  = 1;
    localparam logic [2:0]  GAIN_RST  = 3'h1;
    localparam logic [3:0]  DELAY_RST = 4'h0;
    localparam logic [15:0] X_RST     = 16'h0000;
    localparam logic [15:0] OVF_CODE  = 16'hF000;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    // Mode select codes.
    localparam logic [1:0] MODE_CONT   = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_IDLE   = 2'h2;
    localparam logic [1:0] MODE_SLEEP  = 2'h3;
    localparam logic [1:0] MODE_RST    = MODE_IDLE;

    // Serial bus bit counts.
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BIT_LAST  = 4'h7;

    // ------------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        I_IDLE = 7'h01,
        I_ADDR = 7'h02,
        I_AACK = 7'h04,
        I_WR   = 7'h08,
        I_WACK = 7'h10,
        I_RD   = 7'h20,
        I_RACK = 7'h40
    } mgxo_bus_e;

    typedef enum logic [2:0] {
        M_OFF    = 3'h1,
        M_SETTLE = 3'h2,
        M_CONV   = 3'h4
    } mgxo_meas_e;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } mgxo_pin_s;

    typedef struct packed {
        logic              done;
        logic              ovf;
        logic signed [11:0] x;
    } mgxo_adc_s;

    typedef struct packed {
        logic             busy;
        logic             done;
        logic [TMR_W-1:0] cnt;
    } mgxo_tmr_s;

    typedef struct packed {
        logic        scl_s;
        logic        sda_s;
        logic        scl_p;
        logic        sda_p;
        mgxo_bus_e   ist;
        logic [3:0]  bitcnt;
        logic [7:0]  shreg;
        logic        rw;
        logic        ack;
        logic        ptr_first;
        logic [7:0]  ptr;
        logic        drv;
        logic [2:0]  gain;
        logic [3:0]  delay;
        logic [1:0]  mode;
        logic [15:0] x;
        logic [15:0] pend_x;
        logic        pend;
        logic        pend_now;
        logic [OUT_REGS-1:0] rd_mask;
        logic        drdy;
        mgxo_meas_e  ms;
        logic        adc_start;
    } mgxo_state_s;

endpackage

// ==== mgxo_timer.sv ====
// One-shot cycle timer that pulses done a programmed number of cycles after start.
`timescale 1ns/10ps
`default_nettype none

module mgxo_timer
    import mgxo_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Control
    input  wire logic             start_i,
    input  wire logic [TMR_W-1:0] count_i,
    // Status
    output logic                  busy_o,
    output logic                  done_o
);

    localparam logic [TMR_W-1:0] ONE = {{(TMR_W-1){1'b0}}, 1'b1};

    mgxo_tmr_s q;
    mgxo_tmr_s d;

    // A zero count is run as one cycle so that done always follows start.
    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        if (start_i)
        begin
            d.busy = 1'b1;
            d.cnt  = (count_i == '0) ? ONE : count_i;
        end
        else if (q.busy)
        begin
            d.cnt = q.cnt - ONE;
            if (q.cnt == ONE)
            begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            q <= '0;
        else
            q <= d;
    end

    assign busy_o = q.busy;
    assign done_o = q.done;

endmodule

`default_nettype wire

// ==== mgxo_top.sv ====
// Serial register slave, mode sequencer and X result registers of the magnetometer.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Three-bit gain_sel in the top bits sets the measurement gain.
// - One gain_sel drives all three channels; no per-channel gain.
// - Wait delay_sel times a third millisecond after supply before converting.
// - Delay timing is nominal; tests allow half the value either way.
// - Gain/delay resets to gain 001, delay zero; bytes are sent MSB first.
// - Mode register is readable and writable; low two bits are mode_sel.
// - mode_sel resets to idle, code 10.
// - Mode 00 converts continuously and raises the ready flag on new data.
// - After restart first set comes after two periods, then one per period.
// - Mode 01 measures once, sets ready, rewrites mode_sel to sleep.
// - Single result and ready flag stay until read or next conversion.
// - Modes 10 and 11 are idle and sleep; no conversions run.
// - X result is 16-bit two's complement, upper byte then lower byte.
// - Conversion or bias overflow loads the X result with -4096.
// - Next valid measurement replaces the marker; X registers reset to zero.
// - Pointer advances per access: 08 to 03, 12 and above to 0.
// - Unimplemented addresses read zero; their writes and undefined bits ignored.
// - Once output reading begins, new results wait until all six are read.
module mgxo_top
    import mgxo_pkg::*;
#(
    parameter logic [6:0]  SLAVE_ADDR  = 7'h2A, // Value is arbitrary.
    parameter int unsigned DELAY_STEP  = DELAY_STEP_CYC,
    parameter int unsigned OUT_PERIOD  = OUT_PERIOD_CYC
)
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Serial bus pins
    input  wire mgxo_pin_s  pins_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Converter handshake
    input  wire mgxo_adc_s  adc_i,
    output logic            adc_start_o,
    // Analog front end control
    output logic [2:0]      gain_sel_o,
    output logic            sensor_supply_o,
    // Status
    output logic [1:0]      mode_sel_o,
    output logic            data_ready_o,
    output logic            out_lock_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mgxo_state_s      q;
    mgxo_state_s      d;
    logic             scl_rise;
    logic             scl_fall;
    logic             bus_start;
    logic             bus_stop;
    logic             wr_en;
    logic             rd_en;
    logic [7:0]       acc_ptr;
    logic [7:0]       rd_byte;
    logic             restart;
    logic             tick;
    logic             publish;
    logic             per_start;
    logic             per_done;
    logic             set_start;
    logic             set_done;
    logic [TMR_W-1:0] set_count;
    logic [OUT_REGS-1:0] new_mask;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Read data of the register at the pointer; other addresses read zero.
    function automatic logic [7:0] read_reg(input mgxo_state_s s, input logic [7:0] a);
        logic [7:0] r;
        r = BYTE_ZERO;
        case (a)
            REG_CFG_B:   r = {s.gain, 1'b0, s.delay};
            REG_MODE:    r = {6'h00, s.mode};
            REG_X_UPPER: r = s.x[15:8];
            REG_X_LOWER: r = s.x[7:0];
            default:     r = BYTE_ZERO;
        endcase
        return r;
    endfunction

    // Pointer step after each register access.
    function automatic logic [7:0] next_ptr(input logic [7:0] a);
        logic [7:0] n;
        n = a + 8'h01;
        if (a == REG_OUT_LAST)
            n = REG_X_UPPER;
        else if (a >= REG_PTR_TOP)
            n = REG_PTR_ZERO;
        return n;
    endfunction

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------

    // Output period timer for continuous operation.
    mgxo_timer u_period
    (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .start_i (per_start),
        .count_i (TMR_W'(OUT_PERIOD)),
        .busy_o  (),
        .done_o  (per_done)
    );

    // Conversion start delay timer after the supply is switched on.
    mgxo_timer u_settle
    (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .start_i (set_start),
        .count_i (set_count),
        .busy_o  (),
        .done_o  (set_done)
    );

    assign set_count = TMR_W'(q.delay) * TMR_W'(DELAY_STEP);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        d           = q;
        d.adc_start = 1'b0;
        d.scl_s     = pins_i.scl;
        d.sda_s     = pins_i.sda;
        d.scl_p     = q.scl_s;
        d.sda_p     = q.sda_s;
        scl_rise    = q.scl_s & ~q.scl_p;
        scl_fall    = ~q.scl_s & q.scl_p;
        bus_start   = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
        bus_stop    = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        acc_ptr     = q.ptr;
        rd_byte     = read_reg(q, q.ptr);
        restart     = 1'b0;
        tick        = 1'b0;
        publish     = 1'b0;
        per_start   = 1'b0;
        set_start   = 1'b0;
        new_mask    = q.rd_mask;

        // Serial byte engine; bits are taken on SCL rise, driven on SCL fall.
        case (q.ist)
            I_IDLE:
            begin
                d.drv = 1'b0;
            end
            I_ADDR:
            begin
                if (scl_rise)
                begin
                    d.shreg  = {q.shreg[6:0], q.sda_s};
                    d.bitcnt = q.bitcnt + 4'h1;
                end
                if (scl_fall && q.bitcnt == BITS_BYTE)
                begin
                    if (q.shreg[7:1] == SLAVE_ADDR)
                    begin
                        d.rw  = q.shreg[0];
                        d.drv = 1'b1;
                        d.ist = I_AACK;
                    end
                    else
                        d.ist = I_IDLE;
                end
            end
            I_AACK, I_RACK:
            begin
                if (scl_rise && q.ist == I_RACK)
                    d.ack = ~q.sda_s;
                if (scl_fall)
                begin
                    d.bitcnt = 4'h0;
                    if (q.ist == I_RACK && !q.ack)
                    begin
                        d.drv = 1'b0;
                        d.ist = I_IDLE;
                    end
                    else if (q.rw)
                    begin
                        rd_en   = 1'b1;
                        d.shreg = rd_byte;
                        d.drv   = ~rd_byte[7];
                        d.ptr   = next_ptr(q.ptr);
                        d.ist   = I_RD;
                    end
                    else
                    begin
                        d.drv       = 1'b0;
                        d.ptr_first = 1'b1;
                        d.ist       = I_WR;
                    end
                end
            end
            I_WR:
            begin
                if (scl_rise)
                begin
                    d.shreg  = {q.shreg[6:0], q.sda_s};
                    d.bitcnt = q.bitcnt + 4'h1;
                end
                if (scl_fall && q.bitcnt == BITS_BYTE)
                begin
                    d.drv = 1'b1;
                    d.ist = I_WACK;
                    if (q.ptr_first)
                    begin
                        d.ptr       = q.shreg;
                        d.ptr_first = 1'b0;
                    end
                    else
                    begin
                        wr_en = 1'b1;
                        d.ptr = next_ptr(q.ptr);
                    end
                end
            end
            I_WACK:
            begin
                if (scl_fall)
                begin
                    d.drv    = 1'b0;
                    d.bitcnt = 4'h0;
                    d.ist    = I_WR;
                end
            end
            I_RD:
            begin
                if (scl_fall)
                begin
                    d.bitcnt = q.bitcnt + 4'h1;
                    if (q.bitcnt == BIT_LAST)
                    begin
                        d.drv = 1'b0;
                        d.ack = 1'b0;
                        d.ist = I_RACK;
                    end
                    else
                    begin
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.drv   = ~q.shreg[6];
                    end
                end
            end
            default:
            begin
                d.drv = 1'b0;
                d.ist = I_IDLE;
            end
        endcase

        // Start and stop conditions override any byte in progress.
        if (bus_start)
        begin
            d.ist    = I_ADDR;
            d.bitcnt = 4'h0;
            d.drv    = 1'b0;
        end
        else if (bus_stop)
        begin
            d.ist = I_IDLE;
            d.drv = 1'b0;
        end

        // Register writes; undefined bits and unknown addresses are dropped.
        if (wr_en)
        begin
            case (acc_ptr)
                REG_CFG_B:
                begin
                    d.gain  = q.shreg[GAIN_MSB:GAIN_LSB];
                    d.delay = q.shreg[DELAY_MSB:DELAY_LSB];
                    restart = 1'b1;
                end
                REG_MODE:
                begin
                    d.mode  = q.shreg[MODE_MSB:0];
                    restart = 1'b1;
                end
                default:
                    restart = 1'b0;
            endcase
        end

        if (rd_en && acc_ptr >= REG_X_UPPER && acc_ptr <= REG_OUT_LAST)
        begin
            new_mask = q.rd_mask | (OUT_REGS'(1) << (acc_ptr - REG_X_UPPER));
            d.drdy   = 1'b0;
            if (&new_mask)
                new_mask = '0;
            d.rd_mask = new_mask;
        end

        // Measurement sequencer.
        tick = per_done & (q.mode == MODE_CONT) & ~restart;
        if (restart)
        begin
            d.ms       = M_OFF;
            d.pend     = 1'b0;
            d.pend_now = 1'b0;
            per_start  = (d.mode == MODE_CONT);
            if (d.mode == MODE_SINGLE)
            begin
                d.ms      = M_SETTLE;
                set_start = 1'b1;
            end
        end
        else
        begin
            per_start = tick;
            case (q.ms)
                M_OFF:
                begin
                    if (tick)
                    begin
                        d.ms      = M_SETTLE;
                        set_start = 1'b1;
                    end
                end
                M_SETTLE:
                begin
                    if (set_done)
                    begin
                        d.ms        = M_CONV;
                        d.adc_start = 1'b1;
                    end
                end
                M_CONV:
                begin
                    if (adc_i.done)
                    begin
                        d.ms   = M_OFF;
                        d.pend = 1'b1;
                        d.pend_x = adc_i.ovf ? OVF_CODE : 16'(adc_i.x);
                        if (q.mode == MODE_SINGLE)
                        begin
                            d.mode     = MODE_SLEEP;
                            d.pend_now = 1'b1;
                        end
                    end
                end
                default:
                    d.ms = M_OFF;
            endcase
        end

        publish = ~restart & q.pend & (q.rd_mask == '0) & (q.pend_now | tick);
        if (publish)
        begin
            d.x        = q.pend_x;
            d.pend     = (d.ms == M_CONV) ? d.pend : 1'b0;
            d.pend_now = 1'b0;
            d.drdy     = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            q        <= '0;
            q.scl_s  <= 1'b1;
            q.sda_s  <= 1'b1;
            q.scl_p  <= 1'b1;
            q.sda_p  <= 1'b1;
            q.ist    <= I_IDLE;
            q.gain   <= GAIN_RST;
            q.delay  <= DELAY_RST;
            q.mode   <= MODE_RST;
            q.x      <= X_RST;
            q.ms     <= M_OFF;
        end
        else
            q <= d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // one gain for all
    assign gain_sel_o      = q.gain;
    assign sensor_supply_o = (q.ms == M_SETTLE) || (q.ms == M_CONV);
    assign adc_start_o     = q.adc_start;
    assign sda_o           = 1'b0;     // Open drain: only ever pulls low.
    assign sda_oe_o        = q.drv;
    assign mode_sel_o      = q.mode;
    assign data_ready_o    = q.drdy;
    assign out_lock_o      = (q.rd_mask != '0);

endmodule

`default_nettype wire

// ==== mgxo_properties.sv ====
// Checker of the gain, mode and X result block ports.
`timescale 1ns/10ps
`default_nettype none

module mgxo_properties
    import mgxo_pkg::*;
(
    // Watched ports
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire mgxo_pin_s  pins_i,
    input wire logic       sda_oe_o,
    input wire mgxo_adc_s  adc_i,
    input wire logic       adc_start_o,
    input wire logic [2:0] gain_sel_o,
    input wire logic       sensor_supply_o,
    input wire logic [1:0] mode_sel_o,
    input wire logic       data_ready_o,
    input wire logic       out_lock_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Port relations over time.
    a_reset_values: assert property (disable iff (1'b0) srst_i |=>
        mode_sel_o == MODE_RST && gain_sel_o == GAIN_RST && !data_ready_o && !out_lock_o)
        else $error("reset values wrong");
    a_idle_no_conv: assert property (
        mode_sel_o[1] && $past(mode_sel_o[1]) |-> !adc_start_o)
        else $error("conversion in idle or sleep");
    a_single_to_sleep: assert property (
        mode_sel_o == MODE_SINGLE && adc_i.done && sensor_supply_o |=> mode_sel_o == MODE_SLEEP)
        else $error("single mode did not return to sleep");
    a_ready_unlocked: assert property ($rose(data_ready_o) |->
        !$past(out_lock_o) && !out_lock_o)
        else $error("result published while locked");
    a_start_supply: assert property (adc_start_o |-> sensor_supply_o ##1 !adc_start_o)
        else $error("start without supply or not a pulse");
    a_supply_first: assert property ($rose(sensor_supply_o) |-> !adc_start_o)
        else $error("start with no settle time");
    a_ack_scl_low: assert property ($changed(sda_oe_o) |->
        !pins_i.scl && !$past(pins_i.scl))
        else $error("data line moved while bus clock high");
    a_gain_on_write: assert property ($changed(gain_sel_o) |-> ##[0:2] sda_oe_o)
        else $error("gain changed without a write");
endmodule

bind mgxo_top mgxo_properties u_props (
    .clk_i(clk_i), .srst_i(srst_i), .pins_i(pins_i), .sda_oe_o(sda_oe_o),
    .adc_i(adc_i), .adc_start_o(adc_start_o), .gain_sel_o(gain_sel_o),
    .sensor_supply_o(sensor_supply_o), .mode_sel_o(mode_sel_o),
    .data_ready_o(data_ready_o), .out_lock_o(out_lock_o));

`default_nettype wire

// ==== mgxo_host.sv ====
// Bus master model of the host; data line is open drain with a pull-up.
`timescale 1ns/10ps
`default_nettype none

module mgxo_host
    import mgxo_pkg::*;
(
    // Clock and device drive
    input  wire logic      clk_i,
    input  wire logic      dev_oe_i,
    // Resolved bus lines
    output wire mgxo_pin_s pins_o
);
    logic scl_q = 1'b1;
    logic low_q = 1'b0;

    // The line is low while either party pulls it.
    assign pins_o = '{scl: scl_q, sda: ~low_q & ~dev_oe_i};

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Data changes only while the bus clock is low.
    task automatic bit_io(input logic bv, output logic r);
        low_q <= ~bv;
        hold(4);
        scl_q <= 1'b1;
        hold(6);
        r = pins_o.sda;
        scl_q <= 1'b0;
        hold(2);
    endtask

    // Start, also used as a repeated start.
    task automatic start();
        low_q <= 1'b0;
        hold(4);
        scl_q <= 1'b1;
        hold(6);
        low_q <= 1'b1;
        hold(6);
        scl_q <= 1'b0;
        hold(2);
    endtask

    task automatic stop();
        low_q <= 1'b1;
        hold(4);
        scl_q <= 1'b1;
        hold(6);
        low_q <= 1'b0;
        hold(6);
    endtask

    task automatic byte_io(input logic [7:0] w, input logic a,
                           output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
        bit_io(a, k);
    endtask
endmodule

`default_nettype wire

// ==== mgxo_tb_top.sv ====
// Self-checking bench of the gain, mode and X result block.
`timescale 1ns/10ps
`default_nettype none

module mgxo_tb_top
    import mgxo_pkg::*;
;
    localparam int         P    = 2000;
    localparam logic [6:0] ADDR = 7'h2A; // Value is arbitrary.
    typedef struct packed {
        logic [7:0]  ptr;
        logic [7:0]  wr;
        logic [7:0]  rd;
        logic        ovf;
        logic [11:0] x;
        logic [15:0] xe;
    } mgxo_row_s;
    // Rows: pointer, written, read back, converter sample, expected X.
    mgxo_row_s rows [9] = '{
        '{8'h01, 8'hE5, 8'hE5, 1'b0, 12'h000, 16'h0000},
        '{8'h02, 8'hFF, 8'h03, 1'b0, 12'h000, 16'h0000},
        '{8'h0A, 8'h12, 8'h00, 1'b0, 12'h000, 16'h0000},
        '{8'h01, 8'h8F, 8'h8F, 1'b0, 12'h000, 16'h0000},
        '{8'h02, 8'h01, 8'h03, 1'b0, 12'h800, 16'hF800},
        '{8'h02, 8'h01, 8'h03, 1'b0, 12'h7FF, 16'h07FF},
        '{8'h02, 8'h01, 8'h03, 1'b1, 12'h123, 16'hF000},
        '{8'h02, 8'h01, 8'h03, 1'b0, 12'h001, 16'h0001},
        '{8'h02, 8'h02, 8'h02, 1'b0, 12'h000, 16'h0000}};
    logic        clk_i  = 1'b0;
    logic        srst_i = 1'b1;
    logic [2:0]  sh     = 3'h0;
    logic        ovf_q  = 1'b0;
    logic [11:0] x_q    = 12'h000;
    logic [7:0]  b [8];
    logic        k, sda_lv;
    logic        sda_oe, adc_start, supply, drdy, lock;
    logic [2:0]  gain;
    logic [1:0]  mode;
    mgxo_pin_s   pins;
    mgxo_adc_s   adc;
    int          t, st, settle;
    int          err_total = 0;
    int          cmp_count = 0;

    initial forever #12.5 clk_i = ~clk_i;

    // Converter answers three cycles after each start; settle time is measured.
    assign adc = '{sh[2], ovf_q, x_q};
    always @(posedge clk_i)
    begin
        sh <= {sh[1:0], adc_start};
        st <= supply ? st + 1 : 0;
        if (adc_start)
            settle <= st;
    end

    mgxo_top #(.DELAY_STEP(4), .OUT_PERIOD(P)) u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .pins_i(pins), .sda_o(sda_lv), .sda_oe_o(sda_oe),
        .adc_i(adc), .adc_start_o(adc_start), .gain_sel_o(gain), .sensor_supply_o(supply),
        .mode_sel_o(mode), .data_ready_o(drdy), .out_lock_o(lock));
    mgxo_host u_host (.clk_i(clk_i), .dev_oe_i(sda_oe), .pins_o(pins));

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        u_host.start();
        u_host.byte_io({ADDR, 1'b0}, 1'b1, b[0], k);
        u_host.byte_io(p, 1'b1, b[0], k);
        u_host.byte_io(d, 1'b1, b[0], k);
        chk(16'({k, sda_lv}), 16'h0);
        u_host.stop();
    endtask

    // Reads n bytes from pointer p into b, the last one refused.
    task automatic rd(input logic [7:0] p, input int n);
        u_host.start();
        u_host.byte_io({ADDR, 1'b0}, 1'b1, b[0], k);
        u_host.byte_io(p, 1'b1, b[0], k);
        u_host.start();
        u_host.byte_io({ADDR, 1'b1}, 1'b1, b[0], k);
        for (int i = 0; i < n; i++)
            u_host.byte_io(8'hFF, i == n - 1, b[i], k);
        u_host.stop();
    endtask

    task automatic wait_rdy(input int lim);
        for (t = 0; t < lim && drdy !== 1'b1; t++)
            @(posedge clk_i);
        if (t >= lim)
        begin
            err_total++;
            test_done();
        end
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(8'h01, 2);
        chk({b[0], b[1]}, 16'h2002);
        rd(8'h03, 6);
        chk({b[0], b[1]}, X_RST);
        $display("test reset done");
        foreach (rows[i])
        begin
            ovf_q <= rows[i].ovf;
            x_q <= rows[i].x;
            wr(rows[i].ptr, rows[i].wr);
            if (rows[i].ptr == 8'h02 && rows[i].wr == 8'h01)
            begin
                wait_rdy(400);
                chk(16'(mode), 16'(MODE_SLEEP));
                chk(16'(settle >= 30 && settle <= 90), 16'h1);
                rd(8'h08, 6);
                chk({b[1], b[2]}, rows[i].xe);
                chk(16'(drdy), 16'h0);
            end
            rd(rows[i].ptr, 1);
            chk(16'(b[0]), 16'(rows[i].rd));
        end
        chk(16'(gain), 16'h4);
        $display("test table done");
        x_q <= 12'h3A5;
        wr(8'h02, 8'h00);
        wait_rdy(3 * P);
        chk(16'(t > 2 * P - 300 && t < 2 * P + 50), 16'h1);
        rd(8'h03, 1);
        chk(16'({lock, drdy}), 16'h2);
        repeat (P + 100) @(posedge clk_i);
        chk(16'(drdy), 16'h0);
        rd(8'h08, 6);
        chk({b[1], b[2]}, 16'h03A5);
        wait_rdy(P + 50);
        chk(16'(lock), 16'h0);
        wr(8'h02, 8'h02);
        repeat (2 * P) @(posedge clk_i);
        chk(16'(supply), 16'h0);
        $display("test continuous done");
        srst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        chk(16'({gain, mode, drdy}), 16'h000C);
        $display("test second reset done");
        test_done();
    end
endmodule

`default_nettype wire
